// >>> hdl/sas_format.sv
`timescale 1ns/10ps
`include "sas_map.svh"

module sas_format
	import sas_pkg::*;
(
	// raw value and format selection
	input  wire logic [`SAS_DATA_W-1:0] i_value,
	input  wire logic [3:0]             i_bits,
	input  wire logic                   i_signed,
	input  wire logic                   i_left,
	// formatted 16 bit result
	output logic      [`SAS_RES_W-1:0]  o_result
);

	// extend or left align according to resolution
	always_comb
	begin
		case (i_bits)
			`SAS_RES_ALT8:
				if (i_left)
					o_result = {i_value[7:0], 8'h00};
				else if (i_signed)
					o_result = {{8{i_value[7]}}, i_value[7:0]};
				else
					o_result = {8'h00, i_value[7:0]};
			`SAS_RES_ALT10:
				if (i_left)
					o_result = {i_value[9:0], 6'h00};
				else if (i_signed)
					o_result = {{6{i_value[9]}}, i_value[9:0]};
				else
					o_result = {6'h00, i_value[9:0]};
			default:
				if (i_left)
					o_result = {i_value, 4'h0};
				else if (i_signed)
					o_result = {{4{i_value[11]}}, i_value};
				else
					o_result = {4'h0, i_value};
		endcase
	end

endmodule : sas_format

// >>> hdl/sas_map.svh
`ifndef SAS_MAP_SVH
`define SAS_MAP_SVH

// channel counts and indices
`define SAS_NUM_CH      8
`define SAS_INJ_CH      4'h8
// result widths
`define SAS_DATA_W      12
`define SAS_RES_W       16
// resolution codes in bits
`define SAS_RES_FULL    4'hC
`define SAS_RES_ALT10   4'hA
`define SAS_RES_ALT8    4'h8
// extra core clocks per conversion beyond resolution
`define SAS_CONV_EXTRA  4'h2
// positive input code of the temperature sensor
`define SAS_POS_TEMP    4'hB
// negative input selections for single-ended use
`define SAS_NEG_GND     3'h0
`define SAS_NEG_VREF    3'h1
`define SAS_NEG_PIN     3'h2
// default system clocks per converter clock
`define SAS_CORE_DIV    2
// smallest averaging count
`define SAS_AVG_MIN     9'h002
// status flag vector layout
`define SAS_FLG_W       21
`define SAS_FLG_EOS     0
`define SAS_FLG_OVF     1
`define SAS_FLG_COLL    2
`define SAS_FLG_SAT     3
`define SAS_FLG_RNG     12

`endif

// >>> hdl/sas_pkg.sv
`include "sas_map.svh"

package sas_pkg;

	// sequencer states
	typedef enum logic [1:0] {SAS_IDLE, SAS_ACQ, SAS_CONV, SAS_STORE}
		sas_state_t;
	// scan repeat modes
	typedef enum logic [1:0] {SAS_ONESHOT, SAS_PERIODIC, SAS_CONTINUOUS}
		sas_mode_t;
	// scan trigger sources beside firmware
	typedef enum logic [1:0] {SAS_TRIG_NONE, SAS_TRIG_TIMER, SAS_TRIG_PIN,
		SAS_TRIG_PL} sas_trig_t;
	// converter core power modes
	typedef enum logic [1:0] {SAS_PWR_FULL, SAS_PWR_HALF, SAS_PWR_QUARTER}
		sas_pwr_t;

	// per channel configuration
	typedef struct packed {
		logic [3:0] pos_sel;
		logic       diff;
		logic       alt_res;
		logic       avg_en;
		logic [2:0] avg_shift;
		logic       range_en;
		logic [7:0] acq;
	} sas_chan_cfg_t;

	// global configuration
	typedef struct packed {
		logic                  alt_res10;
		logic                  left_align;
		logic                  diff_signed;
		logic                  se_signed;
		logic [2:0]            neg_sel;
		logic [2:0]            neg_pin;
		sas_pwr_t              pwr_mode;
		logic [`SAS_DATA_W-1:0] range_lo;
		logic [`SAS_DATA_W-1:0] range_hi;
	} sas_glb_cfg_t;

	// input multiplexer selection
	typedef struct packed {
		logic [3:0] pos_sel;
		logic [2:0] neg_sel;
		logic [2:0] neg_pin;
		logic       diff;
	} sas_mux_t;

	// result stream to programmable logic
	typedef struct packed {
		logic                  valid;
		logic [3:0]            chan;
		logic [`SAS_RES_W-1:0] data;
	} sas_stream_t;

	// whole state of the sequencer
	typedef struct packed {
		sas_state_t             st;
		logic [3:0]             ch;
		logic [8:0]             cnt;
		logic [8:0]             nsmp;
		logic [19:0]            acc;
		logic [`SAS_DATA_W-1:0] raw;
		logic [7:0]             div;
		logic                   scan_act;
		logic                   run_pend;
		logic                   inj_pend;
		logic [15:0]            per;
		logic [2:0]             pin_sync;
		logic                   pin_lvl;
		logic [`SAS_FLG_W-1:0]  flg;
		logic [8:0]             valid;
		sas_pwr_t               pwr;
		sas_mux_t               mux;
		logic [3:0]             res_bits;
		sas_stream_t            strm;
	} sas_seq_state_t;

endpackage : sas_pkg

// >>> hdl/sas_result_mem.sv
`timescale 1ns/10ps
`include "sas_map.svh"

module sas_result_mem
#(
	parameter int WIDTH = `SAS_RES_W,
	parameter int DEPTH = `SAS_NUM_CH + 1,
	parameter int AW    = 4
)
(
	// clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_srst,
	// write port
	input  wire logic             i_wr_en,
	input  wire logic [AW-1:0]    i_wr_addr,
	input  wire logic [WIDTH-1:0] i_wr_data,
	// read port
	input  wire logic [AW-1:0]    i_rd_addr,
	output logic      [WIDTH-1:0] o_rd_data
);

	logic [WIDTH-1:0] mem_reg [DEPTH];

	// committed results, written only once a result is final
	always_ff @(posedge i_clk)
	begin
		if (i_wr_en && (i_wr_addr < AW'(DEPTH)))
			mem_reg[i_wr_addr] <= i_wr_data;
	end

	// registered read, unmapped entries read zero
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			o_rd_data <= '0;
		else if (i_rd_addr < AW'(DEPTH))
			o_rd_data <= mem_reg[i_rd_addr];
		else
			o_rd_data <= '0;
	end

endmodule : sas_result_mem

// >>> hdl/sas_sequencer.sv
`timescale 1ns/10ps
`include "sas_map.svh"

module sas_sequencer
	import sas_pkg::*;
#(
	parameter int CORE_DIV = `SAS_CORE_DIV
)
(
	// clock and reset
	input  wire logic                   i_clk,
	input  wire logic                   i_srst,
	// global control
	input  wire logic                   i_enable,
	input  wire sas_mode_t              i_scan_mode,
	input  wire sas_trig_t              i_trig_sel,
	input  wire logic [15:0]            i_period,
	input  wire logic [7:0]             i_chan_en,
	input  wire sas_chan_cfg_t [8:0]    i_chan_cfg,
	input  wire sas_glb_cfg_t           i_glb,
	// scan and injection triggers
	input  wire logic                   i_fw_trig,
	input  wire logic                   i_tmr_trig,
	input  wire logic                   i_pin_trig,
	input  wire logic                   i_pl_trig,
	input  wire logic                   i_inj_start,
	// converter core and input multiplexer
	output sas_mux_t                    o_mux,
	output logic                        o_sample,
	output logic                        o_convert,
	output logic                        o_core_clk_en,
	output logic [3:0]                  o_core_bits,
	output sas_pwr_t                    o_pwr_mode,
	input  wire logic [`SAS_DATA_W-1:0] i_conv_data,
	// alternative sequencer
	input  wire logic                   i_alt_en,
	input  wire sas_mux_t               i_alt_mux,
	input  wire logic                   i_alt_sample,
	input  wire logic                   i_alt_convert,
	// result read port
	input  wire logic                   i_rd_en,
	input  wire logic [3:0]             i_rd_idx,
	output logic [`SAS_RES_W-1:0]       o_rd_data,
	output logic [8:0]                  o_valid,
	// result stream
	output sas_stream_t                 o_stream,
	// status
	output logic                        o_busy,
	output logic [`SAS_FLG_W-1:0]       o_flags,
	input  wire logic [`SAS_FLG_W-1:0]  i_flag_clr,
	input  wire logic [`SAS_FLG_W-1:0]  i_irq_mask,
	output logic                        o_irq
);

	localparam logic [7:0] DIV_LD = 8'(CORE_DIV - 1);

	sas_seq_state_t          q_reg;
	sas_seq_state_t          q_next;
	sas_chan_cfg_t           cfg;
	sas_chan_cfg_t           ncfg;
	sas_mux_t                mux_calc;
	logic                    tick;
	logic                    pin_agree;
	logic                    pin_rise;
	logic                    src_trig;
	logic                    per_trig;
	logic                    trig;
	logic [8:0]              avg_tot;
	logic [19:0]             sum;
	logic [19:0]             avg_w;
	logic [`SAS_DATA_W-1:0]  avg;
	logic [`SAS_DATA_W-1:0]  res_mask;
	logic                    last;
	logic                    is_signed;
	logic [`SAS_RES_W-1:0]   fmt;
	logic                    wr_en;
	logic [`SAS_FLG_W-1:0]   flg_set;
	logic [8:0]              val_set;
	logic [8:0]              rd_clr;

	////////////////////////////////////////////////////////////////////////
	// result formatting and double-buffered store

	// signedness depends on conversion type; ground reference is unsigned
	assign is_signed = q_reg.mux.diff ? i_glb.diff_signed
		: (i_glb.se_signed && q_reg.mux.neg_sel != `SAS_NEG_GND);

	sas_format u_format
	(
		.i_value  (avg),
		.i_bits   (q_reg.res_bits),
		.i_signed (is_signed),
		.i_left   (i_glb.left_align),
		.o_result (fmt)
	);

	// store holds only committed results while the next one accumulates
	sas_result_mem #(
		.WIDTH (`SAS_RES_W),
		.DEPTH (`SAS_NUM_CH + 1),
		.AW    (4)
	) u_mem
	(
		.i_clk     (i_clk),
		.i_srst    (i_srst),
		.i_wr_en   (wr_en),
		.i_wr_addr (q_reg.ch),
		.i_wr_data (fmt),
		.i_rd_addr (i_rd_idx),
		.o_rd_data (o_rd_data)
	);

	////////////////////////////////////////////////////////////////////////
	// next state

	always_comb
	begin
		q_next = q_reg;
		cfg = i_chan_cfg[q_reg.ch];
		wr_en = 1'b0;
		flg_set = '0;
		val_set = '0;
		per_trig = 1'b0;
		src_trig = 1'b0;
		q_next.strm.valid = 1'b0;

		// converter clock enable from the divider
		tick = (q_reg.div == 8'h00);
		q_next.div = tick ? DIV_LD : q_reg.div - 8'h01;

		// pin trigger: three stages, change taken when last two agree
		q_next.pin_sync = {q_reg.pin_sync[1:0], i_pin_trig};
		pin_agree = (q_reg.pin_sync[1] == q_reg.pin_sync[2]);
		pin_rise = pin_agree && q_reg.pin_sync[2] && !q_reg.pin_lvl;
		if (pin_agree)
			q_next.pin_lvl = q_reg.pin_sync[2];

		// selected hardware trigger source
		case (i_trig_sel)
			SAS_TRIG_TIMER: src_trig = i_tmr_trig;
			SAS_TRIG_PIN:   src_trig = pin_rise;
			SAS_TRIG_PL:    src_trig = i_pl_trig;
			default:        src_trig = 1'b0;
		endcase

		// periodic scan timer
		if (i_enable && i_scan_mode == SAS_PERIODIC)
		begin
			if (q_reg.per == 16'h0000)
			begin
				per_trig = 1'b1;
				q_next.per = i_period;
			end
			else
				q_next.per = q_reg.per - 16'h0001;
		end
		else
			q_next.per = i_period;

		// scan request; one already waiting or running is a collision
		trig = i_enable && (i_fw_trig || src_trig || per_trig);
		if (trig)
		begin
			if (q_reg.run_pend || q_reg.scan_act)
				flg_set[`SAS_FLG_COLL] = 1'b1;
			else
				q_next.run_pend = 1'b1;
		end

		// injection request, firmware only
		if (i_enable && i_inj_start)
		begin
			if (q_reg.inj_pend)
				flg_set[`SAS_FLG_COLL] = 1'b1;
			else
				q_next.inj_pend = 1'b1;
		end

		// accumulate and average
		sum = q_reg.acc + {8'h00, q_reg.raw};
		avg_tot = `SAS_AVG_MIN << cfg.avg_shift;
		avg_w = cfg.avg_en ? (sum >> ({2'b00, cfg.avg_shift} + 5'h01))
			: sum;
		avg = avg_w[`SAS_DATA_W-1:0];
		last = !cfg.avg_en || ((q_reg.nsmp + 9'h001) >= avg_tot);

		// code mask of the active resolution
		case (q_reg.res_bits)
			`SAS_RES_ALT8:  res_mask = 12'h0FF;
			`SAS_RES_ALT10: res_mask = 12'h3FF;
			default:        res_mask = 12'hFFF;
		endcase

		// sequencer
		case (q_reg.st)
			SAS_IDLE:
				if (!i_enable || i_alt_en)
				begin
					q_next.scan_act = 1'b0;
					q_next.run_pend = 1'b0;
					q_next.inj_pend = 1'b0;
				end
				else if (!q_reg.scan_act && q_reg.inj_pend)
				begin
					// injection slots in between scans
					q_next.ch = `SAS_INJ_CH;
					q_next.st = SAS_ACQ;
					q_next.acc = '0;
					q_next.nsmp = '0;
					q_next.cnt = (i_chan_cfg[8].acq == 8'h00) ? 9'h001
						: {1'b0, i_chan_cfg[8].acq};
				end
				else if (!q_reg.scan_act && q_reg.run_pend)
				begin
					q_next.scan_act = 1'b1;
					q_next.run_pend = 1'b0;
					q_next.ch = 4'h0;
				end
				else if (q_reg.scan_act)
				begin
					if (q_reg.ch == `SAS_INJ_CH)
					begin
						// scan complete
						q_next.scan_act = 1'b0;
						flg_set[`SAS_FLG_EOS] = 1'b1;
						if (i_scan_mode == SAS_CONTINUOUS)
							q_next.run_pend = 1'b1;
					end
					else if (i_chan_en[q_reg.ch[2:0]])
					begin
						q_next.st = SAS_ACQ;
						q_next.acc = '0;
						q_next.nsmp = '0;
						q_next.cnt = (cfg.acq == 8'h00) ? 9'h001
							: {1'b0, cfg.acq};
					end
					else
						q_next.ch = q_reg.ch + 4'h1;
				end
			SAS_ACQ:
				if (tick)
				begin
					if (q_reg.cnt <= 9'h001)
					begin
						q_next.st = SAS_CONV;
						q_next.cnt = {5'h00, q_reg.res_bits}
							+ {5'h00, `SAS_CONV_EXTRA};
					end
					else
						q_next.cnt = q_reg.cnt - 9'h001;
				end
			SAS_CONV:
				if (tick)
				begin
					if (q_reg.cnt <= 9'h001)
					begin
						q_next.st = SAS_STORE;
						q_next.raw = i_conv_data & res_mask;
					end
					else
						q_next.cnt = q_reg.cnt - 9'h001;
				end
			SAS_STORE:
				if (!last)
				begin
					// next sample of the same channel
					q_next.acc = sum;
					q_next.nsmp = q_reg.nsmp + 9'h001;
					q_next.st = SAS_ACQ;
					q_next.cnt = (cfg.acq == 8'h00) ? 9'h001
						: {1'b0, cfg.acq};
				end
				else
				begin
					wr_en = 1'b1;
					val_set[q_reg.ch] = 1'b1;
					if (q_reg.valid[q_reg.ch])
						flg_set[`SAS_FLG_OVF] = 1'b1;
					if (avg == 12'h000 || avg == res_mask)
						flg_set[`SAS_FLG_SAT + q_reg.ch] = 1'b1;
					if (cfg.range_en && (avg < i_glb.range_lo
						|| avg > i_glb.range_hi))
						flg_set[`SAS_FLG_RNG + q_reg.ch] = 1'b1;
					q_next.strm.valid = 1'b1;
					q_next.strm.chan = q_reg.ch;
					q_next.strm.data = fmt;
					if (q_reg.ch == `SAS_INJ_CH)
						q_next.inj_pend = 1'b0;
					else
						q_next.ch = q_reg.ch + 4'h1;
					q_next.st = SAS_IDLE;
				end
			default:
				q_next.st = SAS_IDLE;
		endcase

		// read clears valid; a new result in the same cycle wins
		rd_clr = i_rd_en ? (9'h001 << i_rd_idx) : 9'h000;
		q_next.valid = (q_reg.valid & ~rd_clr) | val_set;
		q_next.flg = (q_reg.flg & ~i_flag_clr) | flg_set;

		// multiplexer setting for the channel about to run
		ncfg = i_chan_cfg[q_next.ch];
		mux_calc.pos_sel = ncfg.pos_sel;
		mux_calc.diff = ncfg.diff;
		mux_calc.neg_sel = i_glb.neg_sel;
		mux_calc.neg_pin = i_glb.neg_pin;
		if (ncfg.pos_sel == `SAS_POS_TEMP)
		begin
			mux_calc.neg_sel = `SAS_NEG_GND;
			mux_calc.diff = 1'b0;
		end
		q_next.mux = i_alt_en ? i_alt_mux : mux_calc;
		if (!ncfg.alt_res)
			q_next.res_bits = `SAS_RES_FULL;
		else if (i_glb.alt_res10)
			q_next.res_bits = `SAS_RES_ALT10;
		else
			q_next.res_bits = `SAS_RES_ALT8;
		q_next.pwr = i_glb.pwr_mode;
	end

	////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			q_reg <= '0;
		else
			q_reg <= q_next;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	// core handshakes, overridden by the alternative sequencer
	assign o_sample = i_alt_en ? i_alt_sample
		: (q_reg.st == SAS_ACQ);
	assign o_convert = i_alt_en ? i_alt_convert
		: (q_reg.st == SAS_CONV);
	assign o_core_clk_en = tick;
	assign o_core_bits = q_reg.res_bits;
	assign o_pwr_mode = q_reg.pwr;
	assign o_mux = q_reg.mux;
	assign o_valid = q_reg.valid;
	assign o_stream = q_reg.strm;
	assign o_busy = (q_reg.st != SAS_IDLE) || q_reg.scan_act;
	assign o_flags = q_reg.flg;
	// each flag reaches the interrupt only when its mask bit is set
	assign o_irq = |(q_reg.flg & i_irq_mask);

endmodule : sas_sequencer

// >>> verification/sas_core_model.sv
`timescale 1ns/10ps
`include "sas_map.svh"

module sas_core_model
	import sas_pkg::*;
(
	// controls from the sequencer
	input  wire logic                   i_clk,
	input  wire sas_mux_t               i_mux,
	input  wire logic                   i_convert,
	input  wire logic [3:0]             i_bits,
	// code present on each positive input
	input  wire logic [15:0][11:0]      i_codes,
	// code back to the sequencer
	output logic      [`SAS_DATA_W-1:0] o_conv_data
);
	logic [`SAS_DATA_W-1:0] last_reg = 12'h000;

	// code at resolution while converting, a toggling stale value otherwise
	always_comb
	begin
		if (i_convert && i_bits != 4'h0)
			o_conv_data = i_codes[i_mux.pos_sel] >> (12 - i_bits);
		else
			o_conv_data = ~last_reg;
	end

	// remember last driven code
	always @(posedge i_clk)
	begin
		last_reg <= o_conv_data;
	end
endmodule : sas_core_model

// >>> verification/sas_sequencer_properties.sv
`timescale 1ns/10ps
`include "sas_map.svh"

module sas_sequencer_properties
	import sas_pkg::*;
#(
	parameter int CORE_DIV = 2
)
(
	// clock, reset and controls
	input wire logic                  i_clk,
	input wire logic                  i_srst,
	input wire logic                  i_enable,
	input wire logic                  i_fw_trig,
	input wire logic                  i_alt_en,
	input wire logic                  i_alt_sample,
	input wire logic                  i_alt_convert,
	input wire logic                  i_rd_en,
	input wire logic [3:0]            i_rd_idx,
	input wire logic [`SAS_FLG_W-1:0] i_irq_mask,
	// design outputs
	input wire sas_mux_t              o_mux,
	input wire logic                  o_sample,
	input wire logic                  o_convert,
	input wire logic                  o_core_clk_en,
	input wire logic [3:0]            o_core_bits,
	input wire logic [15:0]           o_rd_data,
	input wire logic [8:0]            o_valid,
	input wire sas_stream_t           o_stream,
	input wire logic                  o_busy,
	input wire logic [`SAS_FLG_W-1:0] o_flags,
	input wire logic                  o_irq
);
	logic [4:0] tick_reg;
	logic [4:0] tick_next;

	// core ticks counted while converting
	always_comb
	begin
		tick_next = o_convert ? tick_reg + {4'h0, o_core_clk_en} : 5'h00;
	end

	always_ff @(posedge i_clk)
	begin
		tick_reg <= i_srst ? 5'h00 : tick_next;
	end

	////////////////////////////////////////
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	// accepted start, then busy shortly after
	sequence s_start;
		i_fw_trig && i_enable && !o_busy && !i_alt_en;
	endsequence
	sequence s_busy;
		##[1:3] o_busy;
	endsequence

	a_scan_starts: assert property (s_start |-> s_busy)
		else $error("scan did not start");
	a_conv_ticks: assert property (!i_alt_en && !$past(i_alt_en) &&
		$fell(o_convert) |-> $past(tick_next) ==
		{1'b0, $past(o_core_bits)} + 5'h02)
		else $error("conversion length wrong");
	a_irq_or: assert property (o_irq == |(o_flags & i_irq_mask))
		else $error("irq not masked flags");
	a_temp_neg: assert property (!i_alt_en && !$past(i_alt_en) &&
		o_sample && o_mux.pos_sel == `SAS_POS_TEMP |->
		o_mux.neg_sel == `SAS_NEG_GND && !o_mux.diff)
		else $error("temp sensor not single ended");
	a_alt_pass: assert property (i_alt_en |-> o_sample == i_alt_sample &&
		o_convert == i_alt_convert)
		else $error("alt control not passed");
	a_store_pulse: assert property (o_stream.valid |->
		o_valid[o_stream.chan] ##1 !o_stream.valid)
		else $error("stream pulse wrong");
	a_read_clear: assert property (i_rd_en && i_rd_idx <= `SAS_INJ_CH |=>
		!o_valid[$past(i_rd_idx)] || o_stream.valid)
		else $error("read left valid set");
	a_idx_zero: assert property (i_rd_idx > `SAS_INJ_CH |=>
		o_rd_data == 16'h0000)
		else $error("unmapped index not zero");
	a_core_div: assert property (CORE_DIV > 1 && o_core_clk_en |=>
		!o_core_clk_en)
		else $error("core clock too fast");
endmodule : sas_sequencer_properties

bind sas_sequencer sas_sequencer_properties #(.CORE_DIV(CORE_DIV)) u_props (
	.i_clk, .i_srst, .i_enable, .i_fw_trig, .i_alt_en, .i_alt_sample,
	.i_alt_convert, .i_rd_en, .i_rd_idx, .i_irq_mask, .o_mux, .o_sample,
	.o_convert, .o_core_clk_en, .o_core_bits, .o_rd_data, .o_valid,
	.o_stream, .o_busy, .o_flags, .o_irq);

// >>> verification/sas_sequencer_tb.sv
`timescale 1ns/10ps
`include "sas_map.svh"

module sas_sequencer_tb
	import sas_pkg::*;
;
	// stimulus and observed signals
	logic                i_clk, i_srst, i_enable, i_fw_trig, i_tmr_trig;
	logic                i_pin_trig, i_pl_trig, i_inj_start, i_alt_en;
	logic                i_alt_sample, i_alt_convert, i_rd_en, o_sample;
	logic                o_convert, o_core_clk_en, o_busy, o_irq;
	sas_mode_t           i_scan_mode;
	sas_trig_t           i_trig_sel;
	sas_pwr_t            o_pwr_mode;
	logic [15:0]         i_period, o_rd_data;
	logic [7:0]          i_chan_en;
	sas_chan_cfg_t [8:0] i_chan_cfg;
	sas_glb_cfg_t        i_glb;
	sas_mux_t            i_alt_mux, o_mux;
	sas_stream_t         o_stream;
	logic [11:0]         i_conv_data;
	logic [3:0]          i_rd_idx, o_core_bits;
	logic [8:0]          o_valid;
	logic [20:0]         o_flags, i_flag_clr, i_irq_mask;
	logic [15:0][11:0]   codes;
	wire  [29:0]         st = {o_valid, o_flags};
	int                  errors = 0, n_compared = 0, cyc = 0;
	int                  q[$];

	sas_sequencer #(.CORE_DIV(2)) dut (
		.i_clk, .i_srst, .i_enable, .i_scan_mode, .i_trig_sel, .i_period,
		.i_chan_en, .i_chan_cfg, .i_glb, .i_fw_trig, .i_tmr_trig,
		.i_pin_trig, .i_pl_trig, .i_inj_start, .o_mux, .o_sample,
		.o_convert, .o_core_clk_en, .o_core_bits, .o_pwr_mode,
		.i_conv_data, .i_alt_en, .i_alt_mux, .i_alt_sample,
		.i_alt_convert, .i_rd_en, .i_rd_idx, .o_rd_data, .o_valid,
		.o_stream, .o_busy, .o_flags, .i_flag_clr, .i_irq_mask, .o_irq);
	sas_core_model core (.i_clk, .i_mux(o_mux), .i_convert(o_convert),
		.i_bits(o_core_bits), .i_codes(codes), .o_conv_data(i_conv_data));

	////////////////////////////////////////
	// expected {saturated, result} of one channel
	function automatic logic [16:0] exp_res(input sas_chan_cfg_t c,
		input logic gnd);
		int r, v;
		logic sg;
		r = c.alt_res ? (i_glb.alt_res10 ? 10 : 8) : 12;
		v = codes[c.pos_sel] >> (12 - r);
		sg = c.diff ? i_glb.diff_signed : !gnd && i_glb.se_signed;
		exp_res[16] = v == 0 || v == (1 << r) - 1;
		if (i_glb.left_align)
			v = v << (16 - r);
		else if (sg && v[r-1])
			v = v | (32'hFFFF << r);
		exp_res[15:0] = v[15:0];
	endfunction : exp_res

	task automatic step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : step

	task automatic chk_d(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_d

	task automatic chk_f(input logic [20:0] got, input logic [20:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_f

	task automatic pulse(ref logic s);
		s = 1'b1;
		step(1);
		s = 1'b0;
		step(1);
	endtask : pulse

	task automatic clr();
		i_flag_clr = '1;
		step(1);
		i_flag_clr = '0;
	endtask : clr

	// wait for a status bit, or for idle when b is negative
	task automatic wait_for(input int b);
		int k;
		k = 0;
		while (k < 30000 && (b < 0 ? o_busy !== 1'b0 : st[b] !== 1'b1))
		begin
			step(1);
			k++;
		end
		// a wait that runs out is a hang: count it and close the run
		if (k == 30000)
		begin
			errors++;
			end_sim();
		end
	endtask : wait_for

	task automatic rd(input int idx);
		i_rd_idx = 4'(idx);
		i_rd_en = 1'b1;
		step(1);
		i_rd_en = 1'b0;
		step(1);
	endtask : rd

	// one random scan checked against the model
	task automatic scan_test(input int it);
		logic [20:0] fe;
		logic [16:0] e;
		fe = 21'h000001;
		i_chan_en = 8'($urandom_range(255, 1));
		i_chan_en[0] = i_chan_en[0] || it == 7;
		{i_glb.alt_res10, i_glb.left_align, i_glb.diff_signed,
			i_glb.se_signed} = 4'($urandom);
		i_glb.neg_sel = 3'($urandom_range(2));
		i_glb.pwr_mode = sas_pwr_t'($urandom_range(2));
		for (int k = 0; k < 16; k++)
			codes[k] = 12'($urandom);
		codes[it % 8] = it[0] ? 12'hFFF : 12'h000;
		for (int c = 0; c < 8; c++)
		begin
			i_chan_cfg[c] = 19'($urandom);
			i_chan_cfg[c].pos_sel[3] = 1'b0;
			i_chan_cfg[c].avg_shift[2:1] = 2'h0;
			if (it == 7 && c == 0)
				{i_chan_cfg[c].avg_en, i_chan_cfg[c].avg_shift} = 4'hF;
			i_chan_cfg[c].range_en = 1'b0;
			i_chan_cfg[c].acq[7:2] = 6'h00;
			e = exp_res(i_chan_cfg[c], i_glb.neg_sel == `SAS_NEG_GND);
			fe[3 + c] = e[16] && i_chan_en[c];
			if (i_chan_en[c])
				q.push_back(e[15:0]);
		end
		step(1);
		chk_d(16'(o_pwr_mode), 16'(i_glb.pwr_mode));
		clr();
		pulse(i_fw_trig);
		wait_for(0);
		step(2);
		chk_f(o_flags & 21'h000FFF, fe);
		chk_f(21'(o_valid), 21'(i_chan_en));
		for (int c = 0; c < 8; c++)
			if (i_chan_en[c])
			begin
				rd(c);
				chk_d(o_rd_data, 16'(q.pop_front()));
			end
		rd(9);
		chk_d(o_rd_data, 16'h0000);
		chk_f(21'(o_valid), 21'h000000);
	endtask : scan_test

	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_sim

	////////////////////////////////////////
	// clock and hang guard
	initial
	begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			errors++;
			end_sim();
		end
	end

	// main sequence
	initial
	begin
		sas_chan_cfg_t cf;
		logic [16:0] e;
		{i_srst, i_enable, i_fw_trig, i_tmr_trig, i_pin_trig, i_pl_trig,
			i_inj_start, i_alt_en, i_alt_sample, i_alt_convert,
			i_rd_en} = 11'h400;
		i_scan_mode = SAS_ONESHOT;
		i_trig_sel = SAS_TRIG_NONE;
		{i_period, i_chan_en} = 24'h080000;
		{i_chan_cfg, i_glb, i_alt_mux, i_rd_idx} = '0;
		{i_flag_clr, i_irq_mask, codes} = '0;
		void'($urandom(27103));
		step(16);
		i_srst = 1'b0;
		i_enable = 1'b1;
		for (int it = 0; it < 8; it++)
			scan_test(it);
		$display("test scan done");
		// long averaging stays in the scan test, later scans run short
		i_chan_cfg[0].avg_en = 1'b0;
		i_chan_cfg[8] = 19'($urandom);
		{i_chan_cfg[8].pos_sel, i_chan_cfg[8].diff, i_chan_cfg[8].alt_res,
			i_chan_cfg[8].avg_en} = 7'h5C;
		i_chan_cfg[8].range_en = 1'b0;
		cf = i_chan_cfg[8];
		cf.diff = 1'b0;
		e = exp_res(cf, 1'b1);
		clr();
		pulse(i_inj_start);
		wait_for(29);
		chk_d(16'({o_stream.valid, o_stream.chan}), 16'h0018);
		chk_d(o_stream.data, e[15:0]);
		step(2);
		chk_f(o_flags & 21'h000001, 21'h000000);
		rd(8);
		chk_d(o_rd_data, e[15:0]);
		$display("test inject done");
		clr();
		i_fw_trig = 1'b1;
		step(2);
		i_fw_trig = 1'b0;
		wait_for(-1);
		pulse(i_fw_trig);
		wait_for(-1);
		chk_f(o_flags & 21'h000006, 21'h000006);
		i_irq_mask = 21'h000004;
		step(1);
		chk_f(21'(o_irq), 21'h000001);
		clr();
		chk_f(21'(o_irq), 21'h000000);
		i_irq_mask = 21'h000000;
		for (int c = 0; c < 9; c++)
			rd(c);
		$display("test fault done");
		for (int s = 1; s < 4; s++)
		begin
			i_trig_sel = sas_trig_t'(s);
			clr();
			case (s)
				1: pulse(i_tmr_trig);
				2: i_pin_trig = 1'b1;
				default: pulse(i_pl_trig);
			endcase
			wait_for(0);
			i_pin_trig = 1'b0;
			chk_f(o_flags & 21'h000001, 21'h000001);
		end
		i_trig_sel = SAS_TRIG_NONE;
		for (int m = 1; m < 3; m++)
		begin
			i_scan_mode = sas_mode_t'(m);
			clr();
			pulse(i_fw_trig);
			wait_for(0);
			clr();
			wait_for(0);
			chk_f(o_flags & 21'h000001, 21'h000001);
			i_scan_mode = SAS_ONESHOT;
			i_enable = 1'b0;
			wait_for(-1);
			i_enable = 1'b1;
		end
		$display("test trigger done");
		i_alt_en = 1'b1;
		repeat (8)
		begin
			{i_alt_sample, i_alt_convert} = 2'($urandom);
			i_alt_mux = 11'($urandom);
			step(1);
			chk_d(16'({o_sample, o_convert}),
				16'({i_alt_sample, i_alt_convert}));
			chk_d(16'(o_mux), 16'(i_alt_mux));
		end
		{i_alt_en, i_alt_sample, i_alt_convert} = 3'h0;
		step(2);
		$display("test alt done");
		end_sim();
	end
endmodule : sas_sequencer_tb
